// ### spd_cmp_top.sv
// Speed limit comparator: AXI4-Lite registers, lower/upper limit relays,
// fault relay, in-band flag and interrupt.
// Assumes speed_value, speed_valid, speed_fault and ext_reset_in are
// synchronous to aclk; speed_valid pulses once per new displayed value.
//
// Function
// R1: upper relay on when setpoint <= speed
// R2: lower relay on when setpoint > speed
// R3: in-band only when neither limit relay on
// R4: fault relay on abnormal comparator operation
// R5: three outputs: lower, upper, fault
// R6: reset input turns all relays off
// R7: auto mode releases after speed recrosses setpoint
// R8: hysteresis 1 to 20 percent offsets recovery; code also accepts 0 percent, its reset value
// R9: hold mode keeps relay until reset
// R10: one-shot keeps relay 10..2000 ms
// R11: on-delay 0..1000 ms before relay on
// R12: compare per new sample, timers on clock
`timescale 1ns/1ps
`default_nettype none
module spd_cmp_top
#(
  parameter int TICK_CYCLES = spdcmp_pkg::TICK_CYCLES
)
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [7:0]                   awaddr,
  input  wire logic                         awvalid,
  output var  logic                         awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output var  logic                         wready,
  output var  logic [1:0]                   bresp,
  output var  logic                         bvalid,
  input  wire logic                         bready,
  input  wire logic [7:0]                   araddr,
  input  wire logic                         arvalid,
  output var  logic                         arready,
  output var  logic [31:0]                  rdata,
  output var  logic [1:0]                   rresp,
  output var  logic                         rvalid,
  input  wire logic                         rready,
  input  wire logic [spdcmp_pkg::SPD_W-1:0] speed_value,
  input  wire logic                         speed_valid,
  input  wire logic                         speed_fault,
  input  wire logic                         ext_reset_in,
  output var  logic                         lower_limit_relay,
  output var  logic                         upper_limit_relay,
  output var  logic                         fault_relay,
  output var  logic                         in_band,
  output var  logic                         irq
);
  import spdcmp_pkg::*;

  // Bus state
  logic [7:0]       aw_q;
  logic [7:0]       aw_d;
  logic             aw_full_q;
  logic             aw_full_d;
  logic [31:0]      w_q;
  logic [31:0]      w_d;
  logic [3:0]       strb_q;
  logic [3:0]       strb_d;
  logic             w_full_q;
  logic             w_full_d;
  logic             awready_d;
  logic             wready_d;
  logic             bvalid_d;
  logic [1:0]       bresp_d;
  logic             arready_d;
  logic             rvalid_d;
  logic [31:0]      rdata_d;
  logic [1:0]       rresp_d;
  logic             wr;
  logic [32:0]      wr_old;
  logic [32:0]      rd_sel;
  logic [31:0]      wdat;

  // Settings and results
  logic [1:0]       mode_q;
  logic [1:0]       mode_d;
  logic [SPD_W-1:0] upper_q;
  logic [SPD_W-1:0] upper_d;
  logic [SPD_W-1:0] lower_q;
  logic [SPD_W-1:0] lower_d;
  logic [4:0]       hyst_q;
  logic [4:0]       hyst_d;
  logic [7:0]       shot_q;
  logic [7:0]       shot_d;
  logic [4:0]       delay_q;
  logic [4:0]       delay_d;
  logic [2:0]       mask_q;
  logic [2:0]       mask_d;
  logic [2:0]       ist_q;
  logic [2:0]       ist_d;
  logic [2:0]       w1c;
  logic [2:0]       ev;
  logic             clr_q;
  logic             clr_d;
  logic             clr_now;
  logic [SPD_W-1:0] speed_q;
  logic [SPD_W-1:0] speed_d;
  logic             lo_d;
  logic             up_d;
  logic             fault_d;
  logic             fault_cond;
  logic             in_band_d;
  logic             irq_d;
  logic             tick;

  chan_if lo_if ();
  chan_if up_if ();

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // Top bit flags a mapped offset
  function automatic logic [32:0] rd_mux(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case ({a[7:2], 2'b00})
      OFS_CTRL:     r[CTRL_MODE_LSB +: 2] = mode_q;
      OFS_UPPER:    r[SPD_W-1:0] = upper_q;
      OFS_LOWER:    r[SPD_W-1:0] = lower_q;
      OFS_HYST:     r[4:0] = hyst_q;
      OFS_SHOT:     r[7:0] = shot_q;
      OFS_DELAY:    r[4:0] = delay_q;
      OFS_STATUS:
      begin
        r[BIT_LOWER]   = lower_limit_relay;
        r[BIT_UPPER]   = upper_limit_relay;
        r[BIT_FAULT]   = fault_relay;
        r[BIT_IN_BAND] = in_band;
      end
      OFS_IRQ_STAT: r[2:0] = ist_q;
      OFS_IRQ_MASK: r[2:0] = mask_q;
      OFS_SPEED:    r[SPD_W-1:0] = speed_q;
      default:      r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction

  // AXI4-Lite handshakes; address and data may arrive in either order
  always_comb
  begin
    wr        = aw_full_q && w_full_q;
    aw_full_d = (aw_full_q || (awvalid && awready)) && !wr;
    aw_d      = (awvalid && awready) ? awaddr : aw_q;
    w_full_d  = (w_full_q || (wvalid && wready)) && !wr;
    w_d       = (wvalid && wready) ? wdata : w_q;
    strb_d    = (wvalid && wready) ? wstrb : strb_q;
    wr_old    = rd_mux(aw_q);
    wdat      = merge(wr_old[31:0], w_q, strb_q);
    bvalid_d  = wr || (bvalid && !bready);
    bresp_d   = bresp;
    if (wr)
      bresp_d = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    rd_sel    = rd_mux(araddr);
    rvalid_d  = (arvalid && arready) || (rvalid && !rready);
    arready_d = !rvalid_d;
    rdata_d   = rdata;
    rresp_d   = rresp;
    if (arvalid && arready)
    begin
      rdata_d = rd_sel[31:0];
      rresp_d = rd_sel[32] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Register writes, sticky events and relay results
  always_comb
  begin
    mode_d  = mode_q;
    upper_d = upper_q;
    lower_d = lower_q;
    hyst_d  = hyst_q;
    shot_d  = shot_q;
    delay_d = delay_q;
    mask_d  = mask_q;
    clr_d   = 1'b0;
    w1c     = 3'h0;
    if (wr && wr_old[32])
    begin
      unique case ({aw_q[7:2], 2'b00})
        OFS_CTRL:
        begin
          mode_d = wdat[CTRL_MODE_LSB +: 2];
          clr_d  = wdat[CTRL_CLR_BIT] && strb_q[0];
        end
        OFS_UPPER:    upper_d = wdat[SPD_W-1:0];
        OFS_LOWER:    lower_d = wdat[SPD_W-1:0];
        OFS_HYST:     hyst_d = wdat[4:0];
        OFS_SHOT:     shot_d = wdat[7:0];
        OFS_DELAY:    delay_d = wdat[4:0];
        OFS_IRQ_STAT: w1c = w_q[2:0] & {3{strb_q[0]}};
        OFS_IRQ_MASK: mask_d = wdat[2:0];
        default:      ;
      endcase
    end
    speed_d    = speed_valid ? speed_value : speed_q;
    clr_now    = ext_reset_in || clr_q;
    // Inverted limits or a reserved mode make the comparison meaningless
    fault_cond = speed_fault || (lower_q > upper_q) || (mode_q == MODE_BAD); // R4
    fault_d    = !clr_now && (fault_relay || fault_cond); // R4 R6
    lo_d       = lo_if.active; // R5
    up_d       = up_if.active; // R5
    in_band_d  = !(lo_d || up_d); // R3
    ev         = {fault_d && !fault_relay, up_d && !upper_limit_relay,
                  lo_d && !lower_limit_relay};
    // New event wins over a clear in the same cycle
    ist_d      = (ist_q & ~w1c) | ev;
    irq_d      = |(ist_q & mask_q);
  end

  assign lo_if.setpoint = lower_q;
  assign lo_if.speed    = speed_value;
  assign lo_if.sample   = speed_valid; // R12
  assign lo_if.clr      = clr_now; // R6
  assign lo_if.hyst     = hyst_q;
  assign lo_if.mode     = mode_q;
  assign lo_if.shot     = shot_q;
  assign lo_if.delay    = delay_q;
  assign up_if.setpoint = upper_q;
  assign up_if.speed    = speed_value;
  assign up_if.sample   = speed_valid; // R12
  assign up_if.clr      = clr_now; // R6
  assign up_if.hyst     = hyst_q;
  assign up_if.mode     = mode_q;
  assign up_if.shot     = shot_q;
  assign up_if.delay    = delay_q;

  tick_gen #(.CYCLES(TICK_CYCLES)) u_tick
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  limit_channel #(.UPPER(1'b0)) u_lower
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .ch      (lo_if.chan)
  );

  limit_channel #(.UPPER(1'b1)) u_upper
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .ch      (up_if.chan)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q              <= 8'h00;
      aw_full_q         <= 1'b0;
      w_q               <= 32'h0000_0000;
      strb_q            <= 4'h0;
      w_full_q          <= 1'b0;
      awready           <= 1'b0;
      wready            <= 1'b0;
      bvalid            <= 1'b0;
      bresp             <= RESP_OKAY;
      arready           <= 1'b0;
      rvalid            <= 1'b0;
      rdata             <= 32'h0000_0000;
      rresp             <= RESP_OKAY;
      mode_q            <= MODE_AUTO;
      upper_q           <= SETPT_RST;
      lower_q           <= SETPT_RST;
      hyst_q            <= HYST_RST;
      shot_q            <= SHOT_RST;
      delay_q           <= DELAY_RST;
      mask_q            <= MASK_RST;
      ist_q             <= 3'h0;
      clr_q             <= 1'b0;
      speed_q           <= SETPT_RST;
      lower_limit_relay <= 1'b0;
      upper_limit_relay <= 1'b0;
      fault_relay       <= 1'b0;
      in_band           <= 1'b1; // R3
      irq               <= 1'b0;
    end
    else
    begin
      aw_q              <= aw_d;
      aw_full_q         <= aw_full_d;
      w_q               <= w_d;
      strb_q            <= strb_d;
      w_full_q          <= w_full_d;
      awready           <= awready_d;
      wready            <= wready_d;
      bvalid            <= bvalid_d;
      bresp             <= bresp_d;
      arready           <= arready_d;
      rvalid            <= rvalid_d;
      rdata             <= rdata_d;
      rresp             <= rresp_d;
      mode_q            <= mode_d;
      upper_q           <= upper_d;
      lower_q           <= lower_d;
      hyst_q            <= hyst_d;
      shot_q            <= shot_d;
      delay_q           <= delay_d;
      mask_q            <= mask_d;
      ist_q             <= ist_d;
      clr_q             <= clr_d;
      speed_q           <= speed_d;
      lower_limit_relay <= lo_d;
      upper_limit_relay <= up_d;
      fault_relay       <= fault_d;
      in_band           <= in_band_d;
      irq               <= irq_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_relays_off;
    !lower_limit_relay && !upper_limit_relay;
  endsequence

  chk_band_excl: // R3
    assert property (in_band == !(lower_limit_relay || upper_limit_relay))
    else $error("in-band flag disagrees with limit relays");
  chk_relay_map: // R5
    assert property (lo_if.active != up_if.active |=>
                     lower_limit_relay == $past(lo_if.active) &&
                     upper_limit_relay == $past(up_if.active))
    else $error("relay outputs mapped to wrong channel");
  chk_ext_clear: // R6
    assert property (ext_reset_in |=> !fault_relay ##1 s_relays_off)
    else $error("reset input did not turn relays off");
  chk_fault_set: // R4
    assert property (fault_cond && !clr_now |=> fault_relay [*1] ##1
                     (fault_relay || $past(clr_now)))
    else $error("fault relay not raised on abnormal operation");
endmodule
`default_nettype wire

// ### spdcmp_pkg.sv
// Constants, register map and state types of the speed limit comparator.
// Assumes a 40 MHz aclk; all other files except tick_gen and relay_load import this package.
package spdcmp_pkg;

  localparam int SPD_W = 20;

  // Timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int SHOT_STEP_MS     = 10;
  localparam int DELAY_STEP_MS    = 50;
  localparam int TICK_TIME_NS     = SHOT_STEP_MS * 1000000;
  localparam int TICK_CYCLES      = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int DELAY_STEP_TICKS = DELAY_STEP_MS / SHOT_STEP_MS;
  localparam int PCT_DIV          = 100;

  // Setting limits
  localparam logic [4:0] HYST_MAX  = 5'h14;
  localparam logic [4:0] DELAY_MAX = 5'h14;
  localparam logic [7:0] SHOT_MAX  = 8'hC8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_UPPER    = 8'h04;
  localparam logic [7:0] OFS_LOWER    = 8'h08;
  localparam logic [7:0] OFS_HYST     = 8'h0C;
  localparam logic [7:0] OFS_SHOT     = 8'h10;
  localparam logic [7:0] OFS_DELAY    = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_SPEED    = 8'h24;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLR_BIT  = 4;
  localparam int BIT_LOWER     = 0;
  localparam int BIT_UPPER     = 1;
  localparam int BIT_FAULT     = 2;
  localparam int BIT_IN_BAND   = 3;

  // Reset values
  localparam logic [SPD_W-1:0] SETPT_RST = 20'h0_0000;
  localparam logic [4:0]       HYST_RST  = 5'h00;
  localparam logic [7:0]       SHOT_RST  = 8'h01;
  localparam logic [4:0]       DELAY_RST = 5'h00;
  localparam logic [2:0]       MASK_RST  = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    MODE_AUTO = 2'h0,
    MODE_HOLD = 2'h1,
    MODE_SHOT = 2'h2,
    MODE_BAD  = 2'h3
  } mode_t;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'h0,
    ST_DELAY  = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_SPENT  = 2'h2
  } chan_state_t;

endpackage

// ### chan_if.sv
// Settings and result of one limit channel.
// Settings driven by the comparator top and read by limit_channel; result driven by limit_channel.
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  import spdcmp_pkg::*;
  logic [SPD_W-1:0] setpoint;
  logic [SPD_W-1:0] speed;
  logic             sample;
  logic             clr;
  logic [4:0]       hyst;
  logic [1:0]       mode;
  logic [7:0]       shot;
  logic [4:0]       delay;
  logic             active;
  modport cfg  (output setpoint, speed, sample, clr, hyst, mode, shot, delay, input active);
  modport chan (input setpoint, speed, sample, clr, hyst, mode, shot, delay, output active);
endinterface
`default_nettype wire

// ### tick_gen.sv
// Free-running divider giving a one-cycle tick every CYCLES clocks.
// Assumes CYCLES of at least 2.
`timescale 1ns/1ps
`default_nettype none
module tick_gen
#(
  parameter int CYCLES = 4
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  output var  logic tick
);
  localparam int           W    = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;

  always_comb
  begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ### limit_channel.sv
// One limit channel: comparison with hysteresis, on-delay and output hold.
// Assumes tick pulses every 10 ms and speed samples synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module limit_channel
#(
  parameter bit UPPER = 1'b1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  chan_if.chan     ch
);
  import spdcmp_pkg::*;
  localparam int BW = SPD_W + 1;

  chan_state_t      state_q;
  chan_state_t      state_d;
  logic             cond_q;
  logic             cond_d;
  logic [7:0]       cnt_q;
  logic [7:0]       cnt_d;
  logic [7:0]       cnt_inc;
  logic [7:0]       dly_tgt;
  logic [7:0]       shot_tgt;
  logic [4:0]       hyst_c;
  logic [4:0]       dly_c;
  logic [SPD_W+4:0] prod;
  logic [BW-1:0]    band;
  logic [BW-1:0]    sp_x;
  logic [BW-1:0]    spd_x;
  logic             trip;
  logic             rel;

  always_comb
  begin
    hyst_c   = (ch.hyst > HYST_MAX) ? HYST_MAX : ch.hyst;
    dly_c    = (ch.delay > DELAY_MAX) ? DELAY_MAX : ch.delay;
    dly_tgt  = 8'(dly_c * DELAY_STEP_TICKS);
    shot_tgt = (ch.shot > SHOT_MAX) ? SHOT_MAX : ((ch.shot == 8'h00) ? 8'h01 : ch.shot);
    prod     = ch.setpoint * hyst_c;
    band     = BW'(prod / PCT_DIV); // R8
    sp_x     = {1'b0, ch.setpoint};
    spd_x    = {1'b0, ch.speed};
    if (UPPER)
    begin
      trip = (spd_x >= sp_x); // R1
      rel  = (spd_x < (sp_x - band)); // R7
    end
    else
    begin
      trip = (spd_x < sp_x); // R2
      rel  = (spd_x >= (sp_x + band)); // R7
    end
    // Between trip and recovery points the previous result holds
    cond_d = cond_q;
    if (ch.clr)
      cond_d = 1'b0;
    else if (ch.sample && trip) // R12
      cond_d = 1'b1;
    else if (ch.sample && rel)
      cond_d = 1'b0;
  end

  // Waits use strictly more ticks than set, since the first tick may come early
  always_comb
  begin
    cnt_inc = cnt_q + 8'h01;
    state_d = state_q;
    cnt_d   = cnt_q;
    if (ch.clr) // R6
    begin
      state_d = ST_IDLE;
      cnt_d   = 8'h00;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (cond_q)
          begin
            cnt_d   = 8'h00;
            state_d = (dly_tgt == 8'h00) ? ST_ACTIVE : ST_DELAY;
          end
        ST_DELAY:
          if (!cond_q) // R11
            state_d = ST_IDLE;
          else if (tick)
          begin
            cnt_d = cnt_inc;
            if (cnt_inc > dly_tgt) // R11
            begin
              state_d = ST_ACTIVE;
              cnt_d   = 8'h00;
            end
          end
        ST_ACTIVE:
          if (ch.mode == MODE_SHOT)
          begin
            if (tick)
            begin
              cnt_d = cnt_inc;
              if (cnt_inc > shot_tgt) // R10
                state_d = ST_SPENT;
            end
          end
          else if (ch.mode != MODE_HOLD && !cond_q) // R7 R9
            state_d = ST_IDLE;
        ST_SPENT:
          if (!cond_q)
            state_d = ST_IDLE;
      endcase
    end
  end

  assign ch.active = (state_q == ST_ACTIVE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      cond_q  <= 1'b0;
      cnt_q   <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cond_q  <= cond_d;
      cnt_q   <= cnt_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_shot_last;
    state_q == ST_ACTIVE && ch.mode == MODE_SHOT && tick && cnt_inc > shot_tgt;
  endsequence

  chk_trip_eval: // R1 R2 R12
    assert property (ch.sample && trip && !ch.clr |=> cond_q)
    else $error("limit crossing not caught on sample");
  chk_hyst_keep: // R8
    assert property (ch.sample && !trip && !rel && !ch.clr |=> $stable(cond_q))
    else $error("result changed inside hysteresis band");
  chk_auto_release: // R7
    assert property (ch.active && ch.mode == MODE_AUTO && !cond_q |=> !ch.active)
    else $error("auto mode did not release output");
  chk_hold_keep: // R9
    assert property (ch.active && ch.mode == MODE_HOLD && !ch.clr |=> ch.active)
    else $error("hold mode dropped output without reset");
  chk_shot_end: // R10
    assert property (s_shot_last |=> !ch.active ##1 !ch.active)
    else $error("one-shot output outlived its time");
  chk_delay_gate: // R11
    assert property (state_q == ST_DELAY && (!tick || !cond_q) |=> !ch.active)
    else $error("output on before delay elapsed");
endmodule
`default_nettype wire

// ### relay_load.sv
// Model of the machinery wired to the relay contacts: counts closings.
// Assumes relay levels are registered on aclk.
`timescale 1ns/1ps
`default_nettype none
module relay_load
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       upper_on,
  input  wire logic       fault_on,
  output var  logic [7:0] upper_closes,
  output var  logic [7:0] fault_closes
);
  logic upper_q;
  logic fault_q;
  // Counts closings, not levels: a held contact is one machine stop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upper_q      <= 1'b0;
      fault_q      <= 1'b0;
      upper_closes <= 8'h00;
      fault_closes <= 8'h00;
    end
    else
    begin
      upper_q <= upper_on;
      fault_q <= fault_on;
      if (upper_on && !upper_q)
        upper_closes <= upper_closes + 8'h01;
      if (fault_on && !fault_q)
        fault_closes <= fault_closes + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### speed_limit_comparator_tb_top.sv
// Self-checking bench: register bus tasks, speed samples, relay checks.
// Assumes spdcmp_pkg; timer tick shortened to 20 clocks.
`timescale 1ns/1ps
`default_nettype none
module speed_limit_comparator_tb_top;
  import spdcmp_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       awaddr = 8'h00;
  logic [7:0]       araddr = 8'h00;
  logic             awvalid = 1'b0;
  logic             wvalid = 1'b0;
  // Response ready stays high: every answer is taken at the edge it shows
  logic             bready = 1'b1;
  logic             arvalid = 1'b0;
  logic             rready = 1'b1;
  logic [31:0]      wdata = 32'h0;
  logic [SPD_W-1:0] speed_value = 20'h00000;
  logic             speed_valid = 1'b0;
  logic             speed_fault = 1'b0;
  logic             ext_reset_in = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp, last_resp;
  logic [31:0]      rdata;
  logic             lower_limit_relay, upper_limit_relay, fault_relay, in_band, irq;
  logic [7:0]       upper_closes, fault_closes;
  int               error_cnt = 0;
  int               checks = 0;
  int               cyc = 0;

  always #12.5 aclk = ~aclk;

  spd_cmp_top #(.TICK_CYCLES(20)) dut_u
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .speed_value(speed_value),
    .speed_valid(speed_valid), .speed_fault(speed_fault),
    .ext_reset_in(ext_reset_in), .lower_limit_relay(lower_limit_relay),
    .upper_limit_relay(upper_limit_relay), .fault_relay(fault_relay),
    .in_band(in_band), .irq(irq)
  );

  relay_load load_u
  (
    .aclk(aclk), .aresetn(aresetn), .upper_on(upper_limit_relay),
    .fault_on(fault_relay), .upper_closes(upper_closes), .fault_closes(fault_closes)
  );

  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    last_resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    last_resp = rresp;
    chk(rdata, e);
  endtask

  // Relay view packed as {in_band, fault, upper, lower}
  task automatic st(input logic [3:0] e);
    chk({28'h0, in_band, fault_relay, upper_limit_relay, lower_limit_relay}, {28'h0, e});
  endtask

  task automatic smp(input logic [SPD_W-1:0] v);
    speed_value <= v;
    speed_valid <= 1'b1;
    @(posedge aclk);
    speed_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic pulse_rst;
    ext_reset_in <= 1'b1;
    @(posedge aclk);
    ext_reset_in <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      test_done;
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_SHOT, 32'h1);
    rd(OFS_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h1);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    // Upper first: lower above upper would count as a fault
    wr(OFS_UPPER, 32'h3E8);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    wr(OFS_LOWER, 32'h1F4);
    smp(20'h2BC);
    st(4'h8);
    smp(20'h3E8);
    st(4'h2);
    smp(20'h1F3);
    st(4'h1);
    smp(20'h1F4);
    st(4'h8);
    rd(OFS_STATUS, 32'h8);
    wr(OFS_HYST, 32'hA);
    smp(20'h3E8);
    smp(20'h384);
    st(4'h2);
    smp(20'h383);
    st(4'h8);
    wr(OFS_CTRL, 32'h1);
    smp(20'h4B0);
    smp(20'h2BC);
    st(4'h2);
    pulse_rst;
    st(4'h8);
    speed_fault <= 1'b1;
    @(posedge aclk);
    speed_fault <= 1'b0;
    repeat (4) @(posedge aclk);
    st(4'hC);
    pulse_rst;
    st(4'h8);
    wr(OFS_CTRL, 32'h3);
    repeat (2) @(posedge aclk);
    st(4'hC);
    // Soft reset together with a legal mode clears the fault for good
    wr(OFS_CTRL, 32'h12);
    repeat (2) @(posedge aclk);
    st(4'h8);
    wr(OFS_SHOT, 32'h2);
    smp(20'h4B0);
    repeat (25) @(posedge aclk);
    st(4'h2);
    repeat (50) @(posedge aclk);
    st(4'h8);
    smp(20'h2BC);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_DELAY, 32'h1);
    smp(20'h4B0);
    repeat (75) @(posedge aclk);
    st(4'h8);
    repeat (60) @(posedge aclk);
    st(4'h2);
    wr(OFS_DELAY, 32'h0);
    smp(20'h2BC);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h0);
    smp(20'h3E8);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    smp(20'h2BC);
    smp(20'h1F3);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    chk({24'h0, upper_closes}, 32'h6);
    chk({24'h0, fault_closes}, 32'h2);
    test_done;
  end
endmodule
`default_nettype wire
